/* File: hdl/lsm_local_stream_ctl.sv */
// local stream memory control: registers, memories and scan sequencing
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - connection and data memories are 4x256 words
// - rows map 16 streams, columns 128 slots
// - host designators translated to physical addresses
// - one mapping fills connection and data memories
// - slower a leaves spare space for b, then c
// - parallel data is one sequential slot stream
// - parallel scan all, even, or every fourth
// - bits 7-6 select conversion mode
// - serial mode: each group field sets rate
// - b needs a not fast; c needs b not fast
// - serial in: a input, c output rate
// - parallel in: a input, c output rate
// - parallel both: a input, c output rate
// - memories read by stream and slot designators
// - all memory operations follow frame-aligned state counter
// - counter modulo 8192: slot, stream, function
// - counter can be cleared and loaded
// - other bus memories share the counter
// - frame follows bus or trunk timing
// - group a 0-7, b 8-11, c 12-15
// - scan a, b, c; skip already-scanned slots
// - parallel only on pins 0-7
// - unassigned slots leave outputs undriven
module lsm_local_stream_ctl import lsm_pkg::*; #(
	parameter int WORDS = MEM_WORDS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// register bus
	input apb_req_s apb_req,
	output apb_rsp_s apb_rsp,
	// frame timing from the clocking section
	input wire logic frame_sync,
	// local stream side
	input wire logic [7:0] rx_byte,
	output state_count_s scan_pos,
	output local_tx_s local_tx
);
	// refuse geometries the mapping cannot serve
	if (WORDS != MEM_WORDS) begin : g_check
		$error("local memory must hold exactly 1024 words");
	end

	// whole state of the block
	typedef struct packed {
		mode_rate_s cfg; // mode and group rates
		logic [16:0] host_addr; // select, stream, slot of host query
		conn_entry_s [WORDS-1:0] conn; // connection memory
		logic [WORDS-1:0][7:0] data0; // data memory bank 0
		logic [WORDS-1:0][7:0] data1; // data memory bank 1
		logic bank; // bank being filled
		local_tx_s tx; // output byte and drive
		apb_rsp_s rsp; // bus answer
		logic diag_clear; // one-cycle counter clear
		logic diag_load; // counter load enable, level
		logic [12:0] load_value; // counter load value
	} state_s;
	state_s st;
	state_s next_st;

	// byte of the bank not being filled, for output steps and host queries
	function automatic logic [7:0] out_byte(input state_s s, input logic [9:0] a);
		out_byte = s.bank ? s.data0[a] : s.data1[a];
	endfunction

	// counter and mapper results
	state_count_s cnt; // live counter
	logic [9:0] scan_addr; // scan location
	logic scan_hit; // scan location in use
	logic [9:0] src_addr; // source of an output connection
	logic src_hit; // source location in use
	logic [9:0] host_loc; // host query location
	logic host_hit; // host query maps
	conn_entry_s scan_entry; // connection word at scan location
	logic out_step; // output function step
	logic access; // apb access phase awaiting answer

	// master state counter
	lsm_state_counter u_counter (
		.mclk(mclk),
		.reset(reset),
		.frame_sync(frame_sync),
		.diag_clear(st.diag_clear),
		.diag_load(st.diag_load),
		.load_value(st.load_value),
		.count(cnt)
	);

	// scan mapping, input side on fill step, output side on drive step
	lsm_addr_map u_scan_map (
		.cfg(st.cfg),
		.scan(1'b1),
		.out_side(out_step),
		.stream(cnt.stream),
		.slot({3'b000, cnt.slot}),
		.addr(scan_addr),
		.hit(scan_hit)
	);

	// source designators of a connection, through the same mapping
	lsm_addr_map u_src_map (
		.cfg(st.cfg),
		.scan(1'b0),
		.out_side(1'b0),
		.stream(scan_entry.stream),
		.slot(scan_entry.slot),
		.addr(src_addr),
		.hit(src_hit)
	);

	// host query designators, output side for the connection memory
	lsm_addr_map u_host_map (
		.cfg(st.cfg),
		.scan(1'b0),
		.out_side(st.host_addr[HA_SEL_BIT]),
		.stream(st.host_addr[HA_STREAM_LSB+:4]),
		.slot(st.host_addr[HA_SLOT_LSB+:10]),
		.addr(host_loc),
		.hit(host_hit)
	);

	// step decode and connection lookup
	assign out_step = (cnt.func == FUNC_OUT);
	assign scan_entry = st.conn[scan_addr];
	assign access = apb_req.psel && apb_req.penable && !st.rsp.pready;

	// next state: scan sequencing, bank swap and register access
	always_comb begin
		logic done;
		logic mem_reg;
		done = 1'b0;
		mem_reg = 1'b0;
		next_st = st;
		next_st.rsp.pready = 1'b0;
		next_st.rsp.pslverr = 1'b0;
		next_st.diag_clear = 1'b0;
		// input step: store the byte of an active stream
		if (cnt.func == FUNC_IN && scan_hit) begin
			if (st.bank) begin
				next_st.data1[scan_addr] = rx_byte;
			end else begin
				next_st.data0[scan_addr] = rx_byte;
			end
		end
		// output step: drive only assigned, active slots
		if (out_step) begin
			next_st.tx.oe = scan_hit && scan_entry.valid && src_hit;
			next_st.tx.data = out_byte(st, src_addr);
		end
		// frame end swaps banks for constant frame delay
		if (cnt == state_count_s'(COUNT_LAST)) begin
			next_st.bank = !st.bank;
		end
		// memory registers wait for the host step of the counter
		mem_reg = apb_req.paddr == REG_HOST_DATA;
		done = access && (!mem_reg || cnt.func == FUNC_HOST);
		if (done) begin
			next_st.rsp.pready = 1'b1;
			next_st.rsp.prdata = 32'h0000_0000;
			case (apb_req.paddr)
				// mode and rate control
				REG_MODE_RATE: begin
					if (apb_req.pwrite) begin
						next_st.cfg = mode_rate_s'(apb_req.pwdata[7:0]);
					end
					next_st.rsp.prdata = {24'h000000, st.cfg};
				end
				// designators of the next memory query
				REG_HOST_ADDR: begin
					if (apb_req.pwrite) begin
						next_st.host_addr = apb_req.pwdata[16:0];
					end
					next_st.rsp.prdata = {15'h0000, st.host_addr};
				end
				// indirect memory access by designators
				REG_HOST_DATA: begin
					if (!host_hit) begin
						next_st.rsp.pslverr = 1'b1;
					end else if (st.host_addr[HA_SEL_BIT]) begin
						if (apb_req.pwrite) begin
							next_st.conn[host_loc] = conn_entry_s'({apb_req.pwdata[HA_SEL_BIT],
								apb_req.pwdata[HA_STREAM_LSB+:4], apb_req.pwdata[HA_SLOT_LSB+:10]});
						end
						next_st.rsp.prdata = {15'h0000, st.conn[host_loc].valid,
							st.conn[host_loc].stream, 2'b00, st.conn[host_loc].slot};
					end else begin
						next_st.rsp.prdata = {24'h000000, out_byte(st, host_loc)};
					end
				end
				// counter clear and load
				REG_DIAG: begin
					if (apb_req.pwrite) begin
						next_st.diag_clear = apb_req.pwdata[DIAG_CLEAR_BIT];
						next_st.diag_load = apb_req.pwdata[DIAG_LOAD_BIT];
						next_st.load_value = apb_req.pwdata[DIAG_VALUE_LSB+:13];
					end
					next_st.rsp.prdata = {3'b000, st.load_value, 14'h0000,
						st.diag_load, 1'b0};
				end
				// live counter, read only
				REG_COUNT: begin
					next_st.rsp.prdata = {19'h00000, cnt};
				end
				// unmapped address
				default: begin
					next_st.rsp.pslverr = 1'b1;
				end
			endcase
		end
	end

	// register the state
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st <= '0;
			st.cfg <= mode_rate_s'(MODE_RATE_RESET);
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flip-flops
	assign apb_rsp = st.rsp;
	assign local_tx = st.tx;
	assign scan_pos = cnt;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// off or unassigned slots never drive
	a_oe_off_rate: assert property (out_step && !scan_hit |=> !local_tx.oe)
		else $error("output driven in an unassigned slot");
	// counter steps by one when left alone
	a_counter_step: assert property (!frame_sync && !st.diag_clear && !st.diag_load
		|=> cnt == state_count_s'($past(cnt) + 13'h0001))
		else $error("state counter did not advance by one");
	// frame pulse realigns the counter
	a_frame_align: assert property (frame_sync && !st.diag_clear && !st.diag_load
		|=> cnt == state_count_s'(13'h0000))
		else $error("counter not aligned to frame");
	// diagnostic load holds the written value
	a_diag_load: assert property (st.diag_load && !st.diag_clear
		|=> cnt == state_count_s'($past(st.load_value)))
		else $error("counter load value not taken");
	// group b silent behind a fast group a
	a_gate_b_rate: assert property (st.cfg.mode == SER_SER && st.cfg.group_a_rate == RATE_8M
		&& cnt.stream[3] && !cnt.stream[2] |-> !scan_hit)
		else $error("group b active while group a runs fast");
	// parallel data only on pins 0-7
	a_par_low_pins: assert property (st.cfg.mode == PAR_PAR && cnt.stream[3] |-> !scan_hit)
		else $error("parallel transfer on an upper pin");
	// middle parallel rate touches even locations only
	a_par_even: assert property (st.cfg.mode == PAR_PAR && st.cfg.group_a_rate == RATE_4M
		&& cnt.func == FUNC_IN && scan_hit |-> !scan_addr[0])
		else $error("odd location scanned at middle parallel rate");
	// slow serial group skips already-scanned slots
	a_skip_slow: assert property (st.cfg.mode == SER_SER && st.cfg.group_a_rate == RATE_2M
		&& !cnt.stream[3] && cnt.slot[1:0] != 2'b00 |-> !scan_hit)
		else $error("slow group transferred twice");
	// memory queries answer only after a host step
	a_host_wait: assert property (apb_rsp.pready && apb_req.paddr == REG_HOST_DATA
		|-> $past(cnt.func) == FUNC_HOST)
		else $error("memory query answered outside host step");
	// mode write lands in the register
	a_mode_write: assert property (access && apb_req.pwrite && apb_req.paddr == REG_MODE_RATE
		|=> st.cfg == mode_rate_s'($past(apb_req.pwdata[7:0])))
		else $error("mode and rate write lost");
	// bank swaps once per counter wrap
	a_bank_swap: assert property (cnt == state_count_s'(COUNT_LAST) |=> st.bank != $past(st.bank))
		else $error("data banks did not swap at frame end");
	// answer lasts exactly one cycle
	a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held longer than one cycle");

	// bus answer content
	// an error only ever comes with the answer
	a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr raised without pready");
	// every answer follows an access phase
	a_answer_access: assert property (apb_rsp.pready |-> $past(access))
		else $error("pready without an access phase");
	// mode register reads back its image
	a_mode_read: assert property (apb_rsp.pready && $past(apb_req.paddr) == REG_MODE_RATE
		|-> apb_rsp.prdata == {24'h000000, $past(st.cfg)})
		else $error("mode and rate read data wrong");
	// counter register reads the live count
	a_count_read: assert property (apb_rsp.pready && $past(apb_req.paddr) == REG_COUNT
		|-> apb_rsp.prdata == {19'h00000, $past(cnt)})
		else $error("counter read data wrong");

	// counter diagnostics and output timing
	// clear wins over load and frame
	a_clear_first: assert property (st.diag_clear |=> cnt == state_count_s'(13'h0000))
		else $error("counter clear not taken");
	// clear request lasts one cycle
	a_clear_pulse: assert property (st.diag_clear |=> !st.diag_clear)
		else $error("counter clear stuck high");
	// output byte changes only after an output step
	a_tx_hold: assert property (!out_step |=> $stable(local_tx))
		else $error("output changed outside an output step");
	// slots without a valid connection stay undriven
	a_invalid_silent: assert property (out_step && !scan_entry.valid |=> !local_tx.oe)
		else $error("output driven without a connection");
	// assigned slots of active groups drive
	a_drive_assigned: assert property (out_step && scan_hit && scan_entry.valid && src_hit
		|=> local_tx.oe)
		else $error("assigned slot not driven");

	// scan order by mode and rate
	// parallel output never on upper pins
	a_par_upper_dark: assert property (st.cfg.mode[0] && out_step && cnt.stream[3] |=> !local_tx.oe)
		else $error("upper pin driven in parallel output mode");
	// top parallel rate scans every location
	a_par_every: assert property (st.cfg.mode == PAR_PAR && st.cfg.group_a_rate == RATE_8M
		&& cnt.func == FUNC_IN && !cnt.stream[3] |-> scan_hit)
		else $error("location skipped at top parallel rate");
	// lowest parallel rate scans every fourth location
	a_par_quarter: assert property (st.cfg.mode == PAR_PAR && st.cfg.group_a_rate == RATE_2M
		&& cnt.func == FUNC_IN && scan_hit |-> scan_addr[1:0] == 2'b00)
		else $error("wrong location scanned at lowest parallel rate");
	// group c silent behind a fast group b
	a_gate_c_rate: assert property (st.cfg.mode == SER_SER && st.cfg.group_b_rate == RATE_8M
		&& cnt.stream[3] && cnt.stream[2] |-> !scan_hit)
		else $error("group c active while group b runs fast");
	// group a off takes and drives nothing
	a_off_group_a: assert property (st.cfg.mode == SER_SER && st.cfg.group_a_rate == RATE_OFF
		&& !cnt.stream[3] |-> !scan_hit)
		else $error("group a active while off");
	// middle serial rate skips odd slots
	a_skip_even: assert property (st.cfg.mode == SER_SER && st.cfg.group_a_rate == RATE_4M
		&& !cnt.stream[3] && cnt.slot[0] |-> !scan_hit)
		else $error("middle rate group transferred twice");
	// slow group b skips already-scanned slots
	a_skip_slow_b: assert property (st.cfg.mode == SER_SER && st.cfg.group_a_rate != RATE_8M
		&& st.cfg.group_b_rate == RATE_2M && cnt.stream[3] && !cnt.stream[2]
		&& cnt.slot[1:0] != 2'b00 |-> !scan_hit)
		else $error("slow group b transferred twice");
endmodule

/* File: hdl/lsm_pkg.sv */
// shared constants, codes and carriers for the local stream memory block
package lsm_pkg;
	// register byte offsets on the apb
	localparam logic [7:0] REG_MODE_RATE = 8'h0C;
	localparam logic [7:0] REG_HOST_ADDR = 8'h10;
	localparam logic [7:0] REG_HOST_DATA = 8'h14;
	localparam logic [7:0] REG_DIAG = 8'h18;
	localparam logic [7:0] REG_COUNT = 8'h1C;
	// reset values
	localparam logic [7:0] MODE_RATE_RESET = 8'h00;
	// host address register fields
	localparam int HA_SLOT_LSB = 0;
	localparam int HA_STREAM_LSB = 12;
	localparam int HA_SEL_BIT = 16;
	// diagnostic register fields
	localparam int DIAG_CLEAR_BIT = 0;
	localparam int DIAG_LOAD_BIT = 1;
	localparam int DIAG_VALUE_LSB = 16;
	// memory and counter geometry
	localparam int MEM_WORDS = 1024;
	localparam int NUM_STREAMS = 16;
	localparam int COUNT_MOD = 8192;
	localparam logic [11:0] MEM_LIMIT = 12'h400;
	localparam logic [12:0] COUNT_LAST = 13'h1FFF;
	// state function codes within one stream step
	localparam logic [1:0] FUNC_IN = 2'h0;
	localparam logic [1:0] FUNC_OUT = 2'h2;
	localparam logic [1:0] FUNC_HOST = 2'h3;
	// stream conversion modes, in field order
	typedef enum logic [1:0] {SER_SER, SER_PAR, PAR_SER, PAR_PAR} conv_mode_e;
	// group rate codes, in field order
	typedef enum logic [1:0] {RATE_OFF, RATE_2M, RATE_4M, RATE_8M} rate_e;
	// mode and rate register image
	typedef struct packed {
		conv_mode_e mode;
		rate_e group_a_rate;
		rate_e group_b_rate;
		rate_e group_c_rate;
	} mode_rate_s;
	// master state counter fields
	typedef struct packed {
		logic [6:0] slot;
		logic [3:0] stream;
		logic [1:0] func;
	} state_count_s;
	// connection memory word, held as designators
	typedef struct packed {
		logic valid;
		logic [3:0] stream;
		logic [9:0] slot;
	} conn_entry_s;
	// apb request and answer
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_s;
	// local output byte with its drive enable
	typedef struct packed {
		logic oe;
		logic [7:0] data;
	} local_tx_s;
endpackage

/* File: hdl/lsm_state_counter.sv */
// master state counter with frame alignment and diagnostic clear and load
`timescale 1ns/1ps
module lsm_state_counter import lsm_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// alignment and diagnostics
	input wire logic frame_sync,
	input wire logic diag_clear,
	input wire logic diag_load,
	input wire logic [12:0] load_value,
	// count
	output state_count_s count
);
	// whole state of the counter
	typedef struct packed {
		logic [12:0] value;
	} ctr_s;
	ctr_s st;
	ctr_s next_st;

	// clear beats load beats frame alignment beats counting
	always_comb begin
		next_st = st;
		if (diag_clear) begin
			next_st.value = 13'h0000;
		end else if (diag_load) begin
			next_st.value = load_value;
		end else if (frame_sync) begin
			next_st.value = 13'h0000;
		end else begin
			next_st.value = st.value + 13'h0001;
		end
	end

	// register the state
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign count = state_count_s'(st.value);
endmodule

/* File: hdl/lsm_addr_map.sv */
// stream and slot designators to physical local memory address
`timescale 1ns/1ps
module lsm_addr_map import lsm_pkg::*; (
	// configuration and side
	input mode_rate_s cfg,
	input wire logic scan,
	input wire logic out_side,
	// designators
	input wire logic [3:0] stream,
	input wire logic [9:0] slot,
	// result
	output logic [9:0] addr,
	output logic hit
);
	// true when the low location bits fit the stride of this rate
	function automatic logic stride_ok(input logic [1:0] sh, input logic [1:0] low);
		stride_ok = (sh == 2'd0) || (sh == 2'd1 && !low[0]) || (sh == 2'd2 && low == 2'd0);
	endfunction

	// size in words of a group at rate r, full being its size at the top rate
	function automatic logic [11:0] group_size(input rate_e r, input logic [11:0] full);
		group_size = (r == RATE_OFF) ? 12'h000 : full >> (2'd3 - 2'(r));
	endfunction

	// one mapping used for fill, scan and host queries alike
	always_comb begin
		logic ser;
		rate_e ra;
		rate_e rb;
		rate_e rc;
		rate_e r;
		logic [1:0] sh;
		logic [11:0] size_a;
		logic [11:0] size_b;
		logic [11:0] base;
		logic [11:0] span;
		logic [11:0] loc;
		logic [9:0] gs;
		logic ok;
		loc = 12'h000;
		gs = 10'h000;
		ok = 1'b0;
		ser = out_side ? !cfg.mode[0] : !cfg.mode[1];
		// serial-serial uses all three groups, other modes one rate per side
		ra = (cfg.mode == SER_SER) ? cfg.group_a_rate
			: (out_side ? cfg.group_c_rate : cfg.group_a_rate);
		rb = (cfg.mode == SER_SER && cfg.group_a_rate != RATE_8M) ? cfg.group_b_rate
			: RATE_OFF;
		rc = (cfg.mode == SER_SER && cfg.group_b_rate != RATE_8M) ? cfg.group_c_rate
			: RATE_OFF;
		// group a pins 0-7, b pins 8-11, c pins 12-15
		r = stream[3] ? (stream[2] ? rc : rb) : ra;
		if (!ser) begin
			r = ra;
		end
		sh = 2'd3 - 2'(r);
		size_a = group_size(ra, 12'h400);
		size_b = group_size(rb, 12'h200);
		base = stream[3] ? (stream[2] ? size_a + size_b : size_a) : 12'h000;
		span = stream[3] ? group_size(stream[2] ? rc : rb, 12'h200) : size_a;
		if (ser) begin
			// slower groups only transfer on their own slot boundary
			if (scan) begin
				ok = stride_ok(sh, slot[1:0]);
				gs = {3'b000, slot[6:0]} >> sh;
			end else begin
				ok = slot < (10'h080 >> sh);
				gs = slot;
			end
			if (stream[3]) begin
				loc = base + {gs, 2'b00} + {10'h000, stream[1:0]};
			end else begin
				loc = {gs[8:0], stream[2:0]};
			end
			ok = ok && (base + span) <= MEM_LIMIT;
		end else begin
			// parallel data is one stream of sequential slots
			if (scan) begin
				loc = {2'b00, slot[6:0], stream[2:0]};
				ok = !stream[3] && stride_ok(sh, loc[1:0]);
			end else begin
				loc = 12'({2'b00, slot} << sh);
				ok = !stream[3] && {1'b0, slot} < (11'h400 >> sh);
			end
		end
		hit = ok && r != RATE_OFF;
		addr = loc[9:0];
	end
endmodule

/* File: tb/lsm_stream_partner.sv */
// local stream device model: feeds input bytes by scan position, counts driven bytes
`timescale 1ns/1ps
module lsm_stream_partner import lsm_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// stream side
	input state_count_s scan_pos,
	input local_tx_s local_tx,
	output logic [7:0] rx_byte,
	output int n_driven
);
	// byte on input steps, inverted elsewhere so a stale byte never looks valid
	always_comb begin
		rx_byte = {scan_pos.stream, scan_pos.slot[3:0]} ^ 8'h5A;
		if (scan_pos.func != FUNC_IN) begin
			rx_byte = ~rx_byte;
		end
	end
	// count cycles in which the output byte is driven
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			n_driven <= 0;
		end else if (local_tx.oe === 1'b1) begin
			n_driven <= n_driven + 1;
		end
	end
endmodule

/* File: tb/test_local_stream_memory_control.sv */
// self-checking bench for the local stream memory control block
`timescale 1ns/1ps
module test_local_stream_memory_control import lsm_pkg::*; ;
	logic mclk; // bench clock
	logic reset; // active high reset
	apb_req_s req; // apb request
	apb_rsp_s rsp; // apb answer
	logic frame_sync; // frame pulse
	logic [7:0] rx_byte; // input byte from the model
	state_count_s scan_pos; // counter position
	local_tx_s local_tx; // output byte
	int n_driven; // driven output cycles
	int n_mismatch;
	int checks_done;
	int model_mode; // behavioural image of the mode register
	int base; // snapshot of driven count
	logic [31:0] rd; // last read data
	logic er; // last error flag

	lsm_local_stream_ctl i_dut (.mclk(mclk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
		.frame_sync(frame_sync), .rx_byte(rx_byte), .scan_pos(scan_pos), .local_tx(local_tx));
	lsm_stream_partner i_partner (.mclk(mclk), .reset(reset), .scan_pos(scan_pos),
		.local_tx(local_tx), .rx_byte(rx_byte), .n_driven(n_driven));

	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// verdict and end of run
	task automatic summarize();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdata, output logic err);
		int n;
		n = 0;
		@(posedge mclk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= wd;
		@(posedge mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		rdata = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (n >= 50) begin
			n_mismatch++;
			summarize();
		end
	endtask

	// designator access: address register, then data register
	task automatic host(input int st, input int sl, input logic sel, input logic wr,
		input logic [31:0] wd);
		logic [31:0] a;
		a = (32'(sel) << HA_SEL_BIT) | (32'(st) << HA_STREAM_LSB) | 32'(sl);
		apb(1'b1, REG_HOST_ADDR, a, rd, er);
		apb(wr, REG_HOST_DATA, wd, rd, er);
	endtask

	// wait until the output step of a stream and slot has landed
	task automatic watch(input int st, input int sl);
		int n;
		n = 0;
		while (!(scan_pos.slot === sl[6:0] && scan_pos.stream === st[3:0]
			&& scan_pos.func === FUNC_OUT) && n < 9000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 9000) begin
			n_mismatch++;
			summarize();
		end
		@(posedge mclk);
		#1;
	endtask

	// expected input byte of a stream and slot
	function automatic logic [7:0] pat(input int st, input int sl);
		return 8'(((st & 15) << 4) | (sl & 15)) ^ 8'h5A;
	endfunction

	// main sequence
	initial begin
		req = '0;
		reset = 1'b1;
		frame_sync = 1'b0;
		n_mismatch = 0;
		checks_done = 0;
		model_mode = 0;
		void'($urandom(32'hbecad104));
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		apb(1'b0, REG_MODE_RATE, 32'h0, rd, er);
		check(rd, 32'(MODE_RATE_RESET));
		// every mode and rate code, then a random image
		for (int i = 0; i < 5; i++) begin
			model_mode = (i < 4) ? i * 8'h55 : $urandom_range(255);
			apb(1'b1, REG_MODE_RATE, ($urandom & 32'hFFFFFF00) | 32'(model_mode), rd, er);
			apb(1'b0, REG_MODE_RATE, 32'h0, rd, er);
			check(rd, 32'(model_mode));
		end
		apb(1'b0, 8'h04, 32'h0, rd, er);
		check(32'(er), 32'h1);
		// counter load, wrap, clear and frame alignment
		apb(1'b1, REG_DIAG, 32'h1FFF0002, rd, er);
		apb(1'b0, REG_COUNT, 32'h0, rd, er);
		check(rd, 32'h1FFF);
		apb(1'b1, REG_DIAG, 32'h0, rd, er);
		apb(1'b0, REG_COUNT, 32'h0, rd, er);
		check(32'(rd < 32), 32'h1);
		repeat (100) @(posedge mclk);
		apb(1'b1, REG_DIAG, 32'h1, rd, er);
		apb(1'b0, REG_COUNT, 32'h0, rd, er);
		check(32'(rd < 32), 32'h1);
		repeat (100) @(posedge mclk);
		frame_sync <= 1'b1;
		@(posedge mclk);
		frame_sync <= 1'b0;
		#1;
		check(32'(scan_pos), 32'h0);
		apb(1'b0, REG_COUNT, 32'h0, rd, er);
		check(32'(rd < 32), 32'h1);
		// serial switching, group a fast
		apb(1'b1, REG_MODE_RATE, 32'h30, rd, er);
		host(1, 5, 1'b1, 1'b1, 32'h00010003);
		check(32'(er), 32'h0);
		host(1, 5, 1'b1, 1'b0, 32'h0);
		check(rd, 32'h00010003);
		watch(1, 5);
		watch(1, 5);
		check(32'(local_tx), 32'({1'b1, pat(0, 3)}));
		watch(1, 6);
		check(32'(local_tx.oe), 32'h0);
		host(0, 3, 1'b0, 1'b0, 32'h0);
		check(rd, 32'(pat(0, 3)));
		// group b refused while group a is fast
		apb(1'b1, REG_MODE_RATE, 32'h34, rd, er);
		host(8, 5, 1'b1, 1'b1, 32'h00010003);
		check(32'(er), 32'h1);
		// upper streams refused in parallel-parallel mode
		apb(1'b1, REG_MODE_RATE, 32'hF3, rd, er);
		host(8, 5, 1'b1, 1'b1, 32'h00010003);
		check(32'(er), 32'h1);
		// all groups off: nothing driven for a frame
		apb(1'b1, REG_MODE_RATE, 32'h0, rd, er);
		watch(1, 5);
		base = n_driven;
		watch(1, 5);
		check(32'(local_tx.oe), 32'h0);
		check(32'(n_driven - base), 32'h0);
		summarize();
	end
endmodule
